// ==== rtl/mor_seq.sv ====
/*
  Machine origin return sequencer for one pulse-train axis, with APB registers.
  Assumes near-point dog and zero signal arrive asynchronously from the drive side.
*/
// Behaviour
// [R1] Stopper start on dog: run at creep speed.
// [R2] No retry; direction fixed for whole return.
// [R3] Start ramps bias to return speed, then holds.
// [R4] Dog on in fast phase: ramp to creep.
// [R5] Stopper 2/3 zero signal: stop pulses, clear.
// [R6] Clear lasts 10 ms, then done set, request cleared.
// [R7] Early zero ends return, abrupt stop.
// [R8] Zero active at start: error 1200, no return.
// [R9] Drive asserts zero only after stopper contact.
// [R10] Stopper 3 ramps bias to creep, no dog.
// [R11] Count 1: zero after movement amount ends return.
// [R12] Drive should limit torque at creep speed.
// [R13] No dog found: stay at return speed.
// [R14] Dog should be longer than stopper distance.
`timescale 1ns/1ps
module mor_seq #(
  parameter int unsigned CLR_CYC = mor_pkg::CLR_TIME_CYC,
  parameter int unsigned MS_CYC  = mor_pkg::MS_TICK_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [mor_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      near_dog_in,
  input  wire logic                      zero_sig_in,
  output logic                           pulse_out,
  output logic                           dir_out,
  output logic                           dev_clr_out,
  output logic                           axis_origin_done_flag,
  output logic                           axis_origin_request_flag
);
  import mor_pkg::*;

  mor_pg_if pg ();

  mor_pulse_gen u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .pg      (pg.gen)
  );

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic dog_s1, dog_s2, zero_s1, zero_s2, zero_s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_s1  <= 1'b0;
      dog_s2  <= 1'b0;
      zero_s1 <= 1'b0;
      zero_s2 <= 1'b0;
      zero_s3 <= 1'b0;
    end else begin
      dog_s1  <= near_dog_in;
      dog_s2  <= dog_s1;
      zero_s1 <= zero_sig_in;
      zero_s2 <= zero_s1;
      zero_s3 <= zero_s2;
    end
  end

  wire logic zero_rise = zero_s2 & ~zero_s3;

  // ----------------------------------------------------------------------
  // APB slave and configuration
  // ----------------------------------------------------------------------
  mor_method_t      mth_reg, mth_next;
  logic             dir_cfg_reg, dir_cfg_next;
  logic [SPD_W-1:0] bias_reg, bias_next, ret_reg, ret_next, creep_reg, creep_next;
  logic [SPD_W-1:0] accel_reg, accel_next, dwell_reg, dwell_next;
  logic [CNT_W-1:0] move_reg, move_next;
  logic             start_reg, start_next;
  logic             pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0]      prdata_reg, prdata_next;
  logic             wr_now;
  logic             err_wr;

  mor_state_t       state_reg, state_next;
  logic             done_reg, done_next, req_reg, req_next;
  logic [15:0]      err_reg, err_next;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == OFS_CTRL) || (a == OFS_BIAS) || (a == OFS_RET) ||
              (a == OFS_CREEP) || (a == OFS_ACCEL) || (a == OFS_MOVE) ||
              (a == OFS_DWELL) || (a == OFS_STATUS);
  endfunction : addr_ok

  always_comb begin
    mth_next     = mth_reg;
    dir_cfg_next = dir_cfg_reg;
    bias_next    = bias_reg;
    ret_next     = ret_reg;
    creep_next   = creep_reg;
    accel_next   = accel_reg;
    move_next    = move_reg;
    dwell_next   = dwell_reg;
    wr_now       = psel & penable & pready_reg & pwrite & addr_ok(paddr);
    err_wr       = wr_now && (paddr == OFS_STATUS);
    start_next   = 1'b0;
    pready_next  = psel & ~penable;
    pslverr_next = psel & ~penable & ~addr_ok(paddr);
    prdata_next  = prdata_reg;
    if (psel && !penable) begin
      prdata_next = '0;
      if (paddr == OFS_CTRL) begin
        prdata_next[CTRL_MTH_LSB +: 2] = mth_reg;
        prdata_next[CTRL_DIR_BIT]      = dir_cfg_reg;
      end else if (paddr == OFS_BIAS) begin
        prdata_next[SPD_W-1:0] = bias_reg;
      end else if (paddr == OFS_RET) begin
        prdata_next[SPD_W-1:0] = ret_reg;
      end else if (paddr == OFS_CREEP) begin
        prdata_next[SPD_W-1:0] = creep_reg;
      end else if (paddr == OFS_ACCEL) begin
        prdata_next[SPD_W-1:0] = accel_reg;
      end else if (paddr == OFS_MOVE) begin
        prdata_next = move_reg;
      end else if (paddr == OFS_DWELL) begin
        prdata_next[SPD_W-1:0] = dwell_reg;
      end else if (paddr == OFS_STATUS) begin
        prdata_next[ST_DONE_BIT]     = done_reg;
        prdata_next[ST_REQ_BIT]      = req_reg;
        prdata_next[ST_BUSY_BIT]     = (state_reg != SQ_IDLE);
        prdata_next[ST_ERR_LSB +: 16] = err_reg;
      end
    end
    if (wr_now) begin
      if (paddr == OFS_CTRL) begin
        mth_next     = mor_method_t'(pwdata[CTRL_MTH_LSB +: 2]);
        dir_cfg_next = pwdata[CTRL_DIR_BIT];
        start_next   = pwdata[CTRL_START_BIT] && (state_reg == SQ_IDLE);
      end else if (paddr == OFS_BIAS) begin
        bias_next = pwdata[SPD_W-1:0];
      end else if (paddr == OFS_RET) begin
        ret_next = pwdata[SPD_W-1:0];
      end else if (paddr == OFS_CREEP) begin
        creep_next = pwdata[SPD_W-1:0];
      end else if (paddr == OFS_ACCEL) begin
        accel_next = pwdata[SPD_W-1:0];
      end else if (paddr == OFS_MOVE) begin
        move_next = pwdata;
      end else if (paddr == OFS_DWELL) begin
        dwell_next = pwdata[SPD_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mth_reg     <= MTH_STOPPER1;
      dir_cfg_reg <= 1'b0;
      bias_reg    <= BIAS_RST;
      ret_reg     <= RET_RST;
      creep_reg   <= CREEP_RST;
      accel_reg   <= ACCEL_RST;
      move_reg    <= MOVE_RST;
      dwell_reg   <= DWELL_RST;
      start_reg   <= 1'b0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      mth_reg     <= mth_next;
      dir_cfg_reg <= dir_cfg_next;
      bias_reg    <= bias_next;
      ret_reg     <= ret_next;
      creep_reg   <= creep_next;
      accel_reg   <= accel_next;
      move_reg    <= move_next;
      dwell_reg   <= dwell_next;
      start_reg   <= start_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Origin return sequencer
  // ----------------------------------------------------------------------
  logic [31:0]      clr_reg, clr_next, msdiv_reg, msdiv_next;
  logic [CNT_W-1:0] pcnt_reg, pcnt_next;
  logic [SPD_W-1:0] dwc_reg, dwc_next;
  logic             tick_reg, tick_next, dogseen_reg, dogseen_next;
  logic             dir_reg, dir_next;
  logic             is_stp, stop_now;

  always_comb begin
    state_next   = state_reg;
    clr_next     = clr_reg;
    pcnt_next    = pcnt_reg;
    dwc_next     = dwc_reg;
    dogseen_next = dogseen_reg;
    dir_next     = dir_reg;
    done_next    = done_reg;
    req_next     = req_reg;
    err_next     = err_reg;
    tick_next    = (msdiv_reg == MS_CYC - 1);
    msdiv_next   = tick_next ? '0 : msdiv_reg + 32'h00000001;
    is_stp       = (mth_reg == MTH_STOPPER2) || (mth_reg == MTH_STOPPER3);
    stop_now     = 1'b0;
    if (err_wr) begin
      err_next = ERR_NONE;
    end
    case (state_reg)
      SQ_IDLE: begin
        if (start_reg) begin
          if (is_stp && zero_s2) begin
            err_next = ERR_ZERO_ON;                               // see [R8]
          end else begin
            req_next     = 1'b1;
            done_next    = 1'b0;
            pcnt_next    = '0;
            dwc_next     = '0;
            dir_next     = dir_cfg_reg;                           // see [R2]
            dogseen_next = dog_s2 && (mth_reg != MTH_STOPPER3);
            if (mth_reg == MTH_STOPPER3) begin
              state_next = SQ_CREEP;                              // see [R10]
            end else if (dog_s2 && mth_reg != MTH_COUNT1) begin
              state_next = SQ_CREEP;                              // see [R1]
            end else begin
              state_next = SQ_FAST;                               // see [R3]
            end
          end
        end
      end
      SQ_FAST: begin
        if (is_stp && zero_rise) begin
          stop_now = 1'b1;                                        // see [R7]
        end else if (dog_s2) begin
          state_next   = SQ_CREEP;                                // see [R4]
          dogseen_next = 1'b1;
        end
      end
      SQ_CREEP: begin
        if (dogseen_reg && pg.pulse && pcnt_reg != '1) begin
          pcnt_next = pcnt_reg + 32'h00000001;
        end
        if (dogseen_reg && tick_reg && dwc_reg != '1) begin
          dwc_next = dwc_reg + 16'h0001;
        end
        if (is_stp && zero_rise) begin
          stop_now = 1'b1;                                        // see [R5]
        end else if (mth_reg == MTH_COUNT1 && dogseen_reg && zero_rise &&
                     pcnt_reg >= move_reg) begin
          stop_now = 1'b1;                                        // see [R11]
        end else if (mth_reg == MTH_STOPPER1 && dogseen_reg && dwc_reg >= dwell_reg) begin
          stop_now = 1'b1;
        end
      end
      SQ_CLEAR: begin
        clr_next = clr_reg + 32'h00000001;
        if (clr_reg == CLR_CYC - 1) begin
          state_next = SQ_IDLE;                                   // see [R6]
          done_next  = 1'b1;
          req_next   = 1'b0;
        end
      end
      default: state_next = SQ_IDLE;
    endcase
    if (stop_now) begin
      state_next = SQ_CLEAR;
      clr_next   = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= SQ_IDLE;
      clr_reg     <= '0;
      msdiv_reg   <= '0;
      tick_reg    <= 1'b0;
      pcnt_reg    <= '0;
      dwc_reg     <= '0;
      dogseen_reg <= 1'b0;
      dir_reg     <= 1'b0;
      done_reg    <= 1'b0;
      req_reg     <= 1'b1;
      err_reg     <= ERR_NONE;
    end else begin
      state_reg   <= state_next;
      clr_reg     <= clr_next;
      msdiv_reg   <= msdiv_next;
      tick_reg    <= tick_next;
      pcnt_reg    <= pcnt_next;
      dwc_reg     <= dwc_next;
      dogseen_reg <= dogseen_next;
      dir_reg     <= dir_next;
      done_reg    <= done_next;
      req_reg     <= req_next;
      err_reg     <= err_next;
    end
  end

  // ----------------------------------------------------------------------
  // Speed ramp
  // ----------------------------------------------------------------------
  logic [SPD_W-1:0] rst_reg, rst_next, el_reg, el_next, spd_reg, spd_next, tgt;
  logic             pls_reg, clro_reg;

  function automatic logic [SPD_W-1:0] ramp_spd(input logic [SPD_W-1:0] s, t, e, a);
    logic signed [33:0] d;
    logic signed [33:0] q;
    d = $signed({18'h00000, t}) - $signed({18'h00000, s});
    q = '0;
    if (e < a) begin
      q = (d * $signed({18'h00000, e})) / $signed({18'h00000, a});
    end
    ramp_spd = (e >= a) ? t : s + q[SPD_W-1:0];
  endfunction : ramp_spd

  always_comb begin
    rst_next = rst_reg;
    el_next  = el_reg;
    tgt      = (state_reg == SQ_FAST) ? ret_reg : creep_reg;
    if (state_reg == SQ_IDLE) begin
      rst_next = bias_reg;                                        // see [R3]
      el_next  = '0;
    end else if (state_reg == SQ_FAST && state_next == SQ_CREEP) begin
      rst_next = spd_reg;                                         // see [R4]
      el_next  = '0;
    end else if (tick_reg && el_reg < accel_reg) begin
      el_next = el_reg + 16'h0001;
    end
    if (state_next == SQ_FAST || state_next == SQ_CREEP) begin
      spd_next = ramp_spd(rst_next, (state_next == SQ_FAST) ? ret_reg : creep_reg,
                          el_next, accel_reg);                    // see [R13]
    end else begin
      spd_next = '0;                                              // see [R7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_reg  <= '0;
      el_reg   <= '0;
      spd_reg  <= '0;
      pls_reg  <= 1'b0;
      clro_reg <= 1'b0;
    end else begin
      rst_reg  <= rst_next;
      el_reg   <= el_next;
      spd_reg  <= spd_next;
      pls_reg  <= pg.pulse && (state_next == SQ_FAST || state_next == SQ_CREEP); // see [R5]
      clro_reg <= (state_next == SQ_CLEAR);                       // see [R6]
    end
  end

  assign pg.speed                 = spd_reg;
  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;
  assign pulse_out                = pls_reg;
  assign dir_out                  = dir_reg;
  assign dev_clr_out              = clro_reg;
  assign axis_origin_done_flag    = done_reg;
  assign axis_origin_request_flag = req_reg;

endmodule : mor_seq

// ==== pkg/mor_pkg.sv ====
/*
  Constants, register map and types of the machine origin return sequencer.
  Assumes a single 20 MHz clock and an APB register port with 32-bit data.
*/
package mor_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned MS_TICK_CYC  = CLK_HZ / MS_PER_S;
  localparam int unsigned CLR_TIME_MS  = 10;
  localparam int unsigned CLR_TIME_CYC = CLR_TIME_MS * MS_TICK_CYC;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SPD_W  = 16;
  localparam int unsigned PHS_W  = 25;
  localparam int unsigned CNT_W  = 32;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BIAS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RET    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CREEP  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ACCEL  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MOVE   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DWELL  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_MTH_LSB   = 1;
  localparam int unsigned CTRL_DIR_BIT   = 3;
  localparam int unsigned ST_DONE_BIT    = 0;
  localparam int unsigned ST_REQ_BIT     = 1;
  localparam int unsigned ST_BUSY_BIT    = 2;
  localparam int unsigned ST_ERR_LSB     = 16;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [SPD_W-1:0] BIAS_RST  = 16'h0064;
  localparam logic [SPD_W-1:0] RET_RST   = 16'h03e8;
  localparam logic [SPD_W-1:0] CREEP_RST = 16'h00c8;
  localparam logic [SPD_W-1:0] ACCEL_RST = 16'h0064;
  localparam logic [CNT_W-1:0] MOVE_RST  = 32'h000003e8;
  localparam logic [SPD_W-1:0] DWELL_RST = 16'h03e8;
  localparam logic [15:0]      ERR_NONE  = 16'h0000;
  localparam logic [15:0]      ERR_ZERO_ON = 16'h04b0;

  typedef enum logic [1:0] {
    MTH_STOPPER1 = 2'h0,
    MTH_STOPPER2 = 2'h1,
    MTH_STOPPER3 = 2'h2,
    MTH_COUNT1   = 2'h3
  } mor_method_t;

  typedef enum logic [3:0] {
    SQ_IDLE  = 4'h1,
    SQ_FAST  = 4'h2,
    SQ_CREEP = 4'h4,
    SQ_CLEAR = 4'h8
  } mor_state_t;

endpackage : mor_pkg

// ==== pkg/mor_pg_if.sv ====
/*
  Link between the sequencer and its pulse generator: commanded rate and pulse.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface mor_pg_if;
  import mor_pkg::*;
  logic [SPD_W-1:0] speed;
  logic             pulse;
  modport gen (input speed, output pulse);
  modport ctl (output speed, input pulse);
endinterface : mor_pg_if

// ==== rtl/mor_pulse_gen.sv ====
/*
  Pulse train generator: emits one-cycle pulses at the commanded rate in Hz.
  Assumes a clock of CLK_HZ; a speed of zero stops output and clears the phase.
*/
`timescale 1ns/1ps
module mor_pulse_gen (
  input wire logic pclk,
  input wire logic presetn,
  mor_pg_if.gen    pg
);
  import mor_pkg::*;

  localparam logic [PHS_W-1:0] PHS_WRAP = PHS_W'(CLK_HZ);

  logic [PHS_W-1:0] phs_reg;
  logic [PHS_W-1:0] phs_next;
  logic             pls_reg;
  logic             pls_next;
  logic [PHS_W-1:0] sum;

  // ----------------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------------
  always_comb begin
    sum      = phs_reg + PHS_W'(pg.speed);
    pls_next = 1'b0;
    phs_next = sum;
    if (pg.speed == '0) begin
      phs_next = '0;
    end else if (sum >= PHS_WRAP) begin
      phs_next = sum - PHS_WRAP;
      pls_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phs_reg <= '0;
      pls_reg <= 1'b0;
    end else begin
      phs_reg <= phs_next;
      pls_reg <= pls_next;
    end
  end

  assign pg.pulse = pls_reg;

endmodule : mor_pulse_gen

// ==== tb/mor_seq_props.sv ====
/* Port checker for the origin return sequencer.
   Assumes it is bound to mor_seq and CLR_CYC matches that instance. */
`timescale 1ns/1ps
module mor_seq_props #(
  parameter int unsigned CLR_CYC = 20
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [mor_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       near_dog_in,
  input wire logic                       zero_sig_in,
  input wire logic                       pulse_out,
  input wire logic                       dir_out,
  input wire logic                       dev_clr_out,
  input wire logic                       axis_origin_done_flag,
  input wire logic                       axis_origin_request_flag
);
  logic [31:0] clr_cnt_reg;
  logic [31:0] clr_cnt_next;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts how long the clear output has been high so far.
  always_comb clr_cnt_next = dev_clr_out ? clr_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_cnt_reg <= 32'h0;
    else clr_cnt_reg <= clr_cnt_next;
  end
  chk_clr_len: assert property (
    $fell(dev_clr_out) |-> clr_cnt_reg == CLR_CYC) else $error("clear length wrong");
  chk_clr_flags: assert property (
    $fell(dev_clr_out) |-> axis_origin_done_flag && !axis_origin_request_flag)
    else $error("flags wrong at clear end");
  chk_done_rise: assert property (
    $rose(axis_origin_done_flag) |-> $fell(dev_clr_out)) else $error("done rose early");
  chk_flag_excl: assert property (
    axis_origin_done_flag |-> !axis_origin_request_flag) else $error("done with request");
  chk_clr_quiet: assert property (
    dev_clr_out |-> !pulse_out) else $error("pulse during clear");
  chk_after_clr: assert property (
    $fell(dev_clr_out) |-> !pulse_out [*4]) else $error("pulse after clear");
  chk_dir_hold: assert property (
    pulse_out |=> $stable(dir_out)) else $error("direction changed in motion");
  chk_rdy_one: assert property (
    psel && !penable |=> pready) else $error("no ready in access");
  chk_rdy_drop: assert property (
    pready |=> !pready) else $error("ready held");
  chk_err_resp: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("bad error response");
  cover property ($fell(dev_clr_out));
  cover property (pslverr);
  cover property ($rose(axis_origin_done_flag));
endmodule : mor_seq_props

// ==== tb/mor_drive_model.sv ====
/* Drive unit with near-point dog, stopper and zero switch or encoder.
   Assumes one step per output pulse; home clears the position. */
`timescale 1ns/1ps
module mor_drive_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pulse_out,
  input  wire logic        dev_clr_out,
  input  wire logic        home,
  input  wire logic [15:0] dog_at,
  input  wire logic [15:0] stop_at,
  input  wire logic        enc,
  input  wire logic        zero_force,
  output logic             near_dog_in,
  output logic             zero_sig_in,
  output logic [15:0]      pos
);
  logic contact;
  logic tick;
  logic cleared;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || home) begin
      pos <= 16'h0;
      tick <= 1'b0;
      cleared <= 1'b0;
    end else begin
      // The stopper blocks further travel at any speed; torque is not modelled.
      if (pulse_out && pos < stop_at) pos <= pos + 16'h1;
      tick <= enc && pulse_out && pos[1:0] == 2'h3;
      if (dev_clr_out) cleared <= 1'b1;
    end
  end
  assign contact = pos >= stop_at;
  // The dog reaches the stopper, so no fast collision.
  assign near_dog_in = pos >= dog_at;
  // Switch zero only after contact, released after clear.
  assign zero_sig_in = zero_force | tick | (!enc & contact & !cleared);
endmodule : mor_drive_model

// ==== tb/tb_machine_origin_return_seq.sv ====
/* Self-checking bench for the origin return sequencer with a drive model.
   Assumes mor_pkg, the design and the checker are compiled first. */
`timescale 1ns/1ps
module tb_machine_origin_return_seq;
  import mor_pkg::*;
  localparam int unsigned CLR = 20;
  localparam int P_RET = CLK_HZ / 65535;
  localparam int P_CR = CLK_HZ / 20000;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, dog, zero, pulse, dir, clr, done, req;
  logic home = 0, enc = 0, zf = 0;
  logic [15:0] dog_at = 16'hffff, stop_at = 16'hffff, pos;
  int cyc, last_p, min_iv, last_iv, npulse, err_count, compares;
  always #25 pclk = ~pclk;
  mor_seq #(.CLR_CYC(CLR), .MS_CYC(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .near_dog_in(dog), .zero_sig_in(zero),
    .pulse_out(pulse), .dir_out(dir), .dev_clr_out(clr), .axis_origin_done_flag(done),
    .axis_origin_request_flag(req));
  mor_drive_model drv (.pclk(pclk), .presetn(presetn), .pulse_out(pulse), .dev_clr_out(clr),
    .home(home), .dog_at(dog_at), .stop_at(stop_at), .enc(enc), .zero_force(zf),
    .near_dog_in(dog), .zero_sig_in(zero), .pos(pos));
  // Pulse spacing monitor and run timeout.
  always @(posedge pclk) begin
    cyc++;
    if (pulse === 1'b1) begin
      if (last_p > 0 && cyc - last_p < min_iv) min_iv = cyc - last_p;
      last_iv = cyc - last_p;
      last_p = cyc;
      npulse++;
    end
    if (cyc == 100000) begin
      err_count++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic near(input int v, input int e);
    check({31'h0, v >= e - 1 && v <= e + 1}, 32'h1);
  endtask : near
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
    check({31'h0, e}, {31'h0, ex});
  endtask : rd
  task automatic run(input logic [1:0] m, input logic [15:0] da, input logic [15:0] sa,
                     input logic en, input int e_min, input int e_last);
    int n;
    logic d;
    d = 1'($urandom % 2);
    home <= 1'b1;
    dog_at <= da;
    stop_at <= sa;
    enc <= en;
    @(posedge pclk);
    home <= 1'b0;
    repeat (3) @(posedge pclk);
    last_p = 0;
    min_iv = 1000000;
    npulse = 0;
    wr(OFS_CTRL, {28'h0, d, m, 1'b1});
    repeat (2) @(posedge pclk);
    rd(OFS_STATUS, 32'h6, 1'b0);
    n = 0;
    while (clr !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, dir}, {31'h0, d});
    near(min_iv, e_min);
    near(last_iv, e_last);
    n = 0;
    while (clr === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(n, CLR);
    check({30'h0, done, req}, 32'h2);
    rd(OFS_STATUS, 32'h1, 1'b0);
  endtask : run
  task automatic results();
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  logic [7:0] ofs [8] = '{OFS_CTRL, OFS_BIAS, OFS_RET, OFS_CREEP, OFS_ACCEL, OFS_MOVE,
                          OFS_DWELL, OFS_STATUS};
  logic [31:0] rv [8] = '{32'h0, 32'(BIAS_RST), 32'(RET_RST), 32'(CREEP_RST),
                          32'(ACCEL_RST), MOVE_RST, 32'(DWELL_RST), 32'h2};
  initial begin
    int n;
    void'($urandom(35));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rd(ofs[i], rv[i], 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(OFS_RET, 32'hffff);
    wr(OFS_CREEP, 32'h4e20);
    wr(OFS_ACCEL, 32'h1);
    wr(OFS_MOVE, 32'h2);
    wr(OFS_DWELL, 32'($urandom_range(3, 1)));
    rd(OFS_RET, 32'hffff, 1'b0);
    run(MTH_STOPPER2, 16'h4, 16'h7, 1'b0, P_RET, P_CR);
    run(MTH_STOPPER2, 16'h0, 16'h3, 1'b0, P_CR, P_CR);
    run(MTH_STOPPER2, 16'hffff, 16'h5, 1'b0, P_RET, P_RET);
    run(MTH_STOPPER3, 16'hffff, 16'h3, 1'b0, P_CR, P_CR);
    run(MTH_COUNT1, 16'h4, 16'hffff, 1'b1, P_RET, P_CR);
    run(MTH_STOPPER1, 16'h4, 16'hffff, 1'b0, P_RET, P_RET);
    home <= 1'b1;
    @(posedge pclk);
    home <= 1'b0;
    npulse = 0;
    wr(OFS_CTRL, {28'h0, 1'b0, MTH_STOPPER3, 1'b1});
    n = 0;
    while (npulse < 2 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    zf <= 1'b1;
    n = 0;
    while (clr !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, clr}, 32'h1);
    repeat (CLR + 4) @(posedge pclk);
    npulse = 0;
    wr(OFS_CTRL, {28'h0, 1'b0, MTH_STOPPER2, 1'b1});
    repeat (100) @(posedge pclk);
    check(npulse, 0);
    rd(OFS_STATUS, {ERR_ZERO_ON, 16'h1}, 1'b0);
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 32'h1, 1'b0);
    zf <= 1'b0;
    results();
  end
endmodule : tb_machine_origin_return_seq
bind mor_seq mor_seq_props #(.CLR_CYC(CLR_CYC)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .near_dog_in(near_dog_in),
  .zero_sig_in(zero_sig_in), .pulse_out(pulse_out), .dir_out(dir_out),
  .dev_clr_out(dev_clr_out), .axis_origin_done_flag(axis_origin_done_flag),
  .axis_origin_request_flag(axis_origin_request_flag));
